// ---- rtl/sacse_pkg.sv ----
// Purpose: Constants for the monitor extremes and CSI-2 error status register bank.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Printed offsets are register indexes; byte address is four times the index.
// Functional notes
// - Monitor 0 peak in bits 6:4, read clears
// - Monitor 0 trough in bits 2:0, resets seven
// - Monitor 1 peak in bits 6:4, read clears
// - Monitor 1 trough in bits 2:0, resets seven
// - Temperature peak in bits 6:4, read clears
// - Temperature trough in bits 2:0, resets seven
// - Eight-bit errored packet count, cleared by read
// - Bit 3 flags short line, read clears
// - Bit 2 flags payload checksum fail, read clears
// - Bit 1 flags header double ECC error
// - Bit 0 flags header single ECC error
// - Per-lane correctable sync error, bits 7 and 3
// - Per-lane uncorrectable sync error, bits 6 and 2
// - Per-lane HS request control error, bits 5, 1
// - Clock lane control error bit 1, rest zero
// - Read-to-clear high and low alarm flags per monitor
package sacse_pkg;

  // Register indexes as printed; the byte address is index times four.
  localparam logic [7:0] IDX_SENSOR_STATUS = 8'h57;
  localparam logic [7:0] IDX_MON0 = 8'h58;
  localparam logic [7:0] IDX_MON1 = 8'h59;
  localparam logic [7:0] IDX_TEMP = 8'h5A;
  localparam logic [7:0] IDX_ERR_CNT = 8'h5C;
  localparam logic [7:0] IDX_PKT_ERR = 8'h5D;
  localparam logic [7:0] IDX_LANE01 = 8'h5E;
  localparam logic [7:0] IDX_LANE23 = 8'h5F;
  localparam logic [7:0] IDX_CLK_LANE = 8'h60;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;

  // Field positions of the extremes registers.
  localparam int PEAK_LSB = 4;
  localparam int TROUGH_LSB = 0;
  localparam int RSV_HI_BIT = 7;
  localparam int RSV_LO_BIT = 3;

  // Lane pair layout: odd lane in the upper nibble, even lane in the lower.
  localparam int LANE_SOFT_BIT = 3;
  localparam int LANE_HARD_BIT = 2;
  localparam int LANE_CTRL_BIT = 1;
  localparam int LANE_ODD_SHIFT = 4;
  localparam int CLK_CTRL_BIT = 1;

  // Reset and idle values, and the error count ceiling.
  localparam logic [2:0] PEAK_NONE = 3'h0;
  localparam logic [2:0] TROUGH_NONE = 3'h7;
  localparam logic [7:0] ERR_CNT_MAX = 8'hFF;

  // Interrupt status bits.
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_PKT = 1;
  localparam int IRQ_LANE = 2;

  localparam int NUM_MON = 3;
  localparam int NUM_LANE = 4;
  localparam int NUM_IRQ = 3;

endpackage

// ---- rtl/sacse_regs_top.sv ----
// Purpose: APB register bank holding monitor extremes, alarm flags and CSI-2 error status.
// Assumes: All event inputs are synchronous to pclk; readings come with a sample strobe.
// Notes: Read-to-clear takes effect at the setup edge, so the returned value and the clear
// Notes: see the same state; an event in that very cycle survives the clear.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module sacse_regs_top (
  input wire logic pclk, // APB clock, 250 MHz.
  input wire logic presetn, // Asynchronous active-low reset.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic mon_sample_valid, // Readings below are valid this cycle.
  input wire logic [2:0] monitor0_reading, // First voltage monitor reading.
  input wire logic [2:0] monitor1_reading, // Second voltage monitor reading.
  input wire logic [2:0] temperature_reading, // Temperature monitor reading.
  input wire logic [2:0] monitor0_high_limit, // First monitor high limit.
  input wire logic [2:0] monitor0_low_limit, // First monitor low limit.
  input wire logic [2:0] monitor1_high_limit, // Second monitor high limit.
  input wire logic [2:0] monitor1_low_limit, // Second monitor low limit.
  input wire logic [2:0] temperature_high_limit, // Temperature high limit.
  input wire logic [2:0] temperature_low_limit, // Temperature low limit.
  input wire logic pkt_end, // One-cycle pulse at the end of a received packet.
  input wire logic short_line_flag, // Line shorter than header word count, with pkt_end.
  input wire logic payload_check_fail, // Payload checksum failure, with pkt_end.
  input wire logic header_double_error, // Uncorrectable header ECC error, with pkt_end.
  input wire logic header_single_error, // Corrected header ECC error, with pkt_end.
  input wire logic [3:0] lane_sync_soft_error, // Per-lane correctable sync error level.
  input wire logic [3:0] lane_sync_hard_error, // Per-lane uncorrectable sync error level.
  input wire logic [3:0] lane_hs_request_ctrl_error, // Per-lane HS request control error.
  input wire logic clocklane_hs_request_ctrl_error, // Clock lane HS request control error.
  output logic irq // Level interrupt, high while an unmasked status bit is set.
);

  // All block state in one record.
  typedef struct packed {
    logic [2:0][1:0] rsv; // Writable reserved bits 7 and 3 of each extremes register.
    logic [2:0][2:0] peak; // Highest reading while above the high limit.
    logic [2:0][2:0] trough; // Lowest reading while below the low limit.
    logic [2:0] alarm_hi; // Sticky high alarm per monitor.
    logic [2:0] alarm_lo; // Sticky low alarm per monitor.
    logic [7:0] err_cnt; // Errored packet count.
    logic [3:0] pkt_err; // Sticky packet error flags.
    logic [3:0] lane_soft; // Sampled lane correctable sync errors.
    logic [3:0] lane_hard; // Sampled lane uncorrectable sync errors.
    logic [3:0] lane_ctrl; // Sampled lane control errors.
    logic clk_ctrl; // Sampled clock lane control error.
    logic [2:0] irq_sts; // Sticky interrupt status.
    logic [2:0] irq_mask; // Interrupt enables.
    logic [31:0] prdata; // Registered read data.
    logic pready; // Registered ready.
    logic pslverr; // Registered error.
    logic irq; // Registered interrupt.
  } sacse_state_s;

  sacse_state_s state_r; // Current state.
  sacse_state_s state_nxt; // Next state.

  // Per-monitor inputs gathered into arrays for the generate loop.
  logic [2:0][2:0] reading; // Readings by monitor.
  logic [2:0][2:0] hi_lim; // High limits by monitor.
  logic [2:0][2:0] lo_lim; // Low limits by monitor.
  logic [2:0] hi_evt; // Reading above its high limit this cycle.
  logic [2:0] lo_evt; // Reading below its low limit this cycle.
  logic [2:0][2:0] peak_nxt; // Peak after clear and update.
  logic [2:0][2:0] trough_nxt; // Trough after clear and update.
  logic [2:0] clr_mon; // Read clear for each extremes register.

  assign reading = {temperature_reading, monitor1_reading, monitor0_reading};
  assign hi_lim = {temperature_high_limit, monitor1_high_limit, monitor0_high_limit};
  assign lo_lim = {temperature_low_limit, monitor1_low_limit, monitor0_low_limit};

  // Address decode: setup phase of a legal word access inside the map.
  logic setup; // First cycle of an APB transfer.
  logic access_done; // Completing edge of an APB transfer.
  logic [7:0] idx; // Register index.
  logic aligned; // Address is word aligned and in range.
  logic rd_setup; // Read in its setup cycle.
  logic mapped; // Index names a register.

  assign setup = psel & ~penable;
  assign access_done = psel & penable & state_r.pready;
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign rd_setup = setup & ~pwrite & aligned;

  // Which index is a register.
  always_comb begin
    case (idx)
      sacse_pkg::IDX_SENSOR_STATUS, sacse_pkg::IDX_MON0, sacse_pkg::IDX_MON1,
      sacse_pkg::IDX_TEMP, sacse_pkg::IDX_ERR_CNT, sacse_pkg::IDX_PKT_ERR,
      sacse_pkg::IDX_LANE01, sacse_pkg::IDX_LANE23, sacse_pkg::IDX_CLK_LANE,
      sacse_pkg::IDX_IRQ_STATUS, sacse_pkg::IDX_IRQ_MASK: begin
        mapped = aligned;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign clr_mon[0] = rd_setup && (idx == sacse_pkg::IDX_MON0);
  assign clr_mon[1] = rd_setup && (idx == sacse_pkg::IDX_MON1);
  assign clr_mon[2] = rd_setup && (idx == sacse_pkg::IDX_TEMP);

  // Per-monitor extremes tracking; the clear is applied first so a new extreme wins.
  genvar m;
  generate
    for (m = 0; m < sacse_pkg::NUM_MON; m++) begin : g_mon
      logic [2:0] peak_base; // Peak after any clear.
      logic [2:0] trough_base; // Trough after any clear.
      assign hi_evt[m] = mon_sample_valid && (reading[m] > hi_lim[m]);
      assign lo_evt[m] = mon_sample_valid && (reading[m] < lo_lim[m]);
      assign peak_base = clr_mon[m] ? sacse_pkg::PEAK_NONE : state_r.peak[m];
      assign trough_base = clr_mon[m] ? sacse_pkg::TROUGH_NONE :
                           state_r.trough[m];
      // Keep the larger reading while above the high limit.
      assign peak_nxt[m] = (hi_evt[m] && (reading[m] > peak_base)) ?
                           reading[m] : peak_base;
      // Keep the smaller reading while below the low limit.
      assign trough_nxt[m] = (lo_evt[m] && (reading[m] < trough_base)) ?
                             reading[m] : trough_base;
    end
  endgenerate

  // Build the read value of one index from the current state.
  function automatic logic [31:0] read_word(input sacse_state_s s, input logic [7:0] i);
    logic [31:0] w;
    int k;
    w = 32'h0000_0000;
    case (i)
      sacse_pkg::IDX_SENSOR_STATUS: begin
        for (k = 0; k < sacse_pkg::NUM_MON; k++) begin
          w[2 * k + 1] = s.alarm_hi[k];
          w[2 * k] = s.alarm_lo[k];
        end
      end
      sacse_pkg::IDX_MON0, sacse_pkg::IDX_MON1, sacse_pkg::IDX_TEMP: begin
        k = (i == sacse_pkg::IDX_MON0) ? 0 : ((i == sacse_pkg::IDX_MON1) ? 1 : 2);
        w[sacse_pkg::RSV_HI_BIT] = s.rsv[k][1];
        w[sacse_pkg::PEAK_LSB +: 3] = s.peak[k];
        w[sacse_pkg::RSV_LO_BIT] = s.rsv[k][0];
        w[sacse_pkg::TROUGH_LSB +: 3] = s.trough[k];
      end
      sacse_pkg::IDX_ERR_CNT: begin
        w[7:0] = s.err_cnt;
      end
      sacse_pkg::IDX_PKT_ERR: begin
        w[3:0] = s.pkt_err;
      end
      sacse_pkg::IDX_LANE01, sacse_pkg::IDX_LANE23: begin
        k = (i == sacse_pkg::IDX_LANE01) ? 0 : 2;
        // Even lane in the low nibble, odd lane shifted up.
        w[sacse_pkg::LANE_SOFT_BIT] = s.lane_soft[k];
        w[sacse_pkg::LANE_HARD_BIT] = s.lane_hard[k];
        w[sacse_pkg::LANE_CTRL_BIT] = s.lane_ctrl[k];
        w[sacse_pkg::LANE_SOFT_BIT + sacse_pkg::LANE_ODD_SHIFT] = s.lane_soft[k + 1];
        w[sacse_pkg::LANE_HARD_BIT + sacse_pkg::LANE_ODD_SHIFT] = s.lane_hard[k + 1];
        w[sacse_pkg::LANE_CTRL_BIT + sacse_pkg::LANE_ODD_SHIFT] = s.lane_ctrl[k + 1];
      end
      sacse_pkg::IDX_CLK_LANE: begin
        w[sacse_pkg::CLK_CTRL_BIT] = s.clk_ctrl;
      end
      sacse_pkg::IDX_IRQ_STATUS: begin
        w[2:0] = s.irq_sts;
      end
      sacse_pkg::IDX_IRQ_MASK: begin
        w[2:0] = s.irq_mask;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // Next-state logic for the whole bank.
  always_comb begin
    logic any_err;
    logic [3:0] pkt_evt;
    logic [2:0] irq_evt;
    logic wr_done;
    any_err = 1'b0;
    pkt_evt = 4'h0;
    irq_evt = 3'h0;
    wr_done = 1'b0;
    state_nxt = state_r;

    // Extremes follow the per-monitor logic.
    state_nxt.peak = peak_nxt;
    state_nxt.trough = trough_nxt;

    // Alarm flags: a read of the sensor status register clears, a crossing sets.
    if (rd_setup && (idx == sacse_pkg::IDX_SENSOR_STATUS)) begin
      state_nxt.alarm_hi = 3'h0;
      state_nxt.alarm_lo = 3'h0;
    end
    state_nxt.alarm_hi = state_nxt.alarm_hi | hi_evt;
    state_nxt.alarm_lo = state_nxt.alarm_lo | lo_evt;

    // Packet errors are qualified by the end-of-packet pulse.
    pkt_evt = {short_line_flag, payload_check_fail, header_double_error,
               header_single_error} & {4{pkt_end}};
    any_err = |pkt_evt;

    // Counter restarts from zero on read; an errored packet in that cycle counts as one.
    if (rd_setup && (idx == sacse_pkg::IDX_ERR_CNT)) begin
      state_nxt.err_cnt = any_err ? 8'h01 : 8'h00;
    end else if (any_err && (state_r.err_cnt != sacse_pkg::ERR_CNT_MAX)) begin
      // Saturating, so a wrapped count never hides a burst of errors.
      state_nxt.err_cnt = state_r.err_cnt + 8'h01;
    end

    // Sticky packet flags, cleared by read, set wins.
    if (rd_setup && (idx == sacse_pkg::IDX_PKT_ERR)) begin
      state_nxt.pkt_err = 4'h0;
    end
    state_nxt.pkt_err = state_nxt.pkt_err | pkt_evt;

    // Lane error flags are read-only and track the receiver each cycle.
    state_nxt.lane_soft = lane_sync_soft_error;
    state_nxt.lane_hard = lane_sync_hard_error;
    state_nxt.lane_ctrl = lane_hs_request_ctrl_error;
    state_nxt.clk_ctrl = clocklane_hs_request_ctrl_error;

    // Interrupt sources: any alarm, any packet error, any lane error.
    irq_evt[sacse_pkg::IRQ_ALARM] = |{hi_evt, lo_evt};
    irq_evt[sacse_pkg::IRQ_PKT] = any_err;
    irq_evt[sacse_pkg::IRQ_LANE] = |{lane_sync_soft_error, lane_sync_hard_error,
                                     lane_hs_request_ctrl_error,
                                     clocklane_hs_request_ctrl_error};
    if (rd_setup && (idx == sacse_pkg::IDX_IRQ_STATUS)) begin
      state_nxt.irq_sts = 3'h0;
    end
    state_nxt.irq_sts = state_nxt.irq_sts | irq_evt;

    // APB: answer one cycle after setup; read data is captured with the clear.
    state_nxt.pready = 1'b0;
    if (setup) begin
      state_nxt.pready = 1'b1;
      state_nxt.pslverr = ~mapped;
      state_nxt.prdata = (~pwrite && mapped) ? read_word(state_r, idx) : 32'h0000_0000;
    end else if (access_done) begin
      state_nxt.pslverr = 1'b0;
    end

    // Writes land at the completing edge; only the reserved bits and mask are writable.
    wr_done = access_done && pwrite && mapped;
    if (wr_done) begin
      case (idx)
        sacse_pkg::IDX_MON0: begin
          state_nxt.rsv[0] = {pwdata[sacse_pkg::RSV_HI_BIT], pwdata[sacse_pkg::RSV_LO_BIT]};
        end
        sacse_pkg::IDX_MON1: begin
          state_nxt.rsv[1] = {pwdata[sacse_pkg::RSV_HI_BIT], pwdata[sacse_pkg::RSV_LO_BIT]};
        end
        sacse_pkg::IDX_TEMP: begin
          state_nxt.rsv[2] = {pwdata[sacse_pkg::RSV_HI_BIT], pwdata[sacse_pkg::RSV_LO_BIT]};
        end
        sacse_pkg::IDX_IRQ_MASK: begin
          state_nxt.irq_mask = pwdata[2:0];
        end
        default: begin
          state_nxt.irq_mask = state_nxt.irq_mask;
        end
      endcase
    end

    // Interrupt is registered from the next status and mask, on the same edge as they change.
    state_nxt.irq = |(state_nxt.irq_sts & state_nxt.irq_mask);
  end

  // State register; troughs reset to the no-alarm value of seven.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
      state_r.trough <= {sacse_pkg::NUM_MON{sacse_pkg::TROUGH_NONE}};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state flip-flops.
  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign irq = state_r.irq;

endmodule // sacse_regs_top

// ---- test/sacse_properties.sv ----
// Purpose: Port-level checks of the monitor extremes and lane error registers.
// Assumes: Limits stay steady while the bench runs.
// Notes: Read data is judged at the edge where the master samples ready.
`timescale 1ns/1ps
module sacse_chk (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Async reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [11:0] paddr, // Byte address.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic [2:0] monitor0_high_limit, // Limit.
  input wire logic [2:0] monitor0_low_limit, // Limit.
  input wire logic [2:0] monitor1_high_limit, // Limit.
  input wire logic [2:0] temperature_high_limit, // Limit.
  input wire logic [2:0] temperature_low_limit, // Limit.
  input wire logic [3:0] lane_sync_soft_error, // Lane levels.
  input wire logic [3:0] lane_sync_hard_error, // Lane levels.
  input wire logic [3:0] lane_hs_request_ctrl_error, // Lane levels.
  input wire logic clocklane_hs_request_ctrl_error // Clock lane level.
);
  logic rd; // A read completes this cycle.
  logic lq; // A read while lane levels have been quiet.
  logic [12:0] cat; // All lane levels together.
  logic [12:0] cat_r; // Lane levels one edge ago.
  logic [1:0] quiet_r; // Edges with unchanged lane levels, saturating.
  assign rd = psel && penable && pready && !pwrite;
  assign cat = {lane_sync_soft_error, lane_sync_hard_error, lane_hs_request_ctrl_error,
    clocklane_hs_request_ctrl_error};
  assign lq = rd && quiet_r == 2'h3 && cat == cat_r;
  // The lane registers lag the pins, so only steady levels are compared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cat_r <= 13'h0000;
      quiet_r <= 2'h0;
    end else begin
      cat_r <= cat;
      quiet_r <= (cat != cat_r) ? 2'h0 : ((quiet_r == 2'h3) ? quiet_r : quiet_r + 2'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_m0_pk;
    rd && paddr == 12'h160 |-> prdata[6:4] == 3'h0 || prdata[6:4] > monitor0_high_limit;
  endproperty
  a_m0_pk: assert property (p_m0_pk) else $error("mon0 peak not above limit");
  property p_m0_tr;
    rd && paddr == 12'h160 |-> prdata[2:0] == 3'h7 || prdata[2:0] < monitor0_low_limit;
  endproperty
  a_m0_tr: assert property (p_m0_tr) else $error("mon0 trough not below limit");
  property p_m1_pk;
    rd && paddr == 12'h164 |-> prdata[6:4] == 3'h0 || prdata[6:4] > monitor1_high_limit;
  endproperty
  a_m1_pk: assert property (p_m1_pk) else $error("mon1 peak not above limit");
  property p_t_pk;
    rd && paddr == 12'h168 |-> prdata[6:4] == 3'h0 || prdata[6:4] > temperature_high_limit;
  endproperty
  a_t_pk: assert property (p_t_pk) else $error("temp peak not above limit");
  property p_t_tr;
    rd && paddr == 12'h168 |-> prdata[2:0] == 3'h7 || prdata[2:0] < temperature_low_limit;
  endproperty
  a_t_tr: assert property (p_t_tr) else $error("temp trough not below limit");
  property p_soft;
    lq && paddr == 12'h178 |-> {prdata[7], prdata[3]} == lane_sync_soft_error[1:0];
  endproperty
  a_soft: assert property (p_soft) else $error("lane sync soft bits wrong");
  property p_ctrl;
    lq && paddr == 12'h17C |-> {prdata[5], prdata[1]} == lane_hs_request_ctrl_error[3:2];
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("lane control bits wrong");
  property p_clk;
    lq && paddr == 12'h180 |-> prdata == {30'h0, clocklane_hs_request_ctrl_error, 1'b0};
  endproperty
  a_clk: assert property (p_clk) else $error("clock lane register wrong");
endmodule // sacse_chk
bind sacse_regs_top sacse_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .monitor0_high_limit(monitor0_high_limit), .monitor0_low_limit(monitor0_low_limit),
  .monitor1_high_limit(monitor1_high_limit), .temperature_high_limit(temperature_high_limit),
  .temperature_low_limit(temperature_low_limit), .lane_sync_soft_error(lane_sync_soft_error),
  .lane_sync_hard_error(lane_sync_hard_error),
  .lane_hs_request_ctrl_error(lane_hs_request_ctrl_error),
  .clocklane_hs_request_ctrl_error(clocklane_hs_request_ctrl_error));

// ---- test/sacse_src.sv ----
// Purpose: Model of the sensor link receiver and analog monitors feeding the bank.
// Assumes: Everything changes just after a rising edge.
// Notes: Qualified lines show inverted values outside their strobe.
`timescale 1ns/1ps
module sacse_src (
  input wire logic pclk, // Clock.
  output logic v, // Sample strobe.
  output logic [2:0] r0, // Monitor 0 reading.
  output logic [2:0] r1, // Monitor 1 reading.
  output logic [2:0] rt, // Temperature reading.
  output logic [2:0] hi, // High limit for all monitors.
  output logic [2:0] lo, // Low limit for all monitors.
  output logic pe, // Packet end pulse.
  output logic [3:0] fl, // Short line, checksum, double, single.
  output logic [3:0] s, // Lane soft sync errors.
  output logic [3:0] h, // Lane hard sync errors.
  output logic [3:0] c, // Lane control errors.
  output logic k // Clock lane control error.
);
  assign hi = 3'h4;
  assign lo = 3'h2;
  // Idle values at time zero.
  initial begin
    {v, r0, r1, rt, pe, fl, s, h, c, k} = 28'h000_0000;
  end
  // One valid sample; the readings become garbage once the strobe drops.
  task automatic sample(input logic [2:0] a, input logic [2:0] b, input logic [2:0] t);
    @(posedge pclk);
    {v, r0, r1, rt} <= {1'b1, a, b, t};
    @(posedge pclk);
    {v, r0, r1, rt} <= {1'b0, ~a, ~b, ~t};
  endtask
  // One packet end with its error flags.
  task automatic pkt(input logic [3:0] f);
    @(posedge pclk);
    {pe, fl} <= {1'b1, f};
    @(posedge pclk);
    {pe, fl} <= {1'b0, ~f};
  endtask
  // Lane error levels hold until changed.
  task automatic lanes(input logic [3:0] a, input logic [3:0] b, input logic [3:0] d,
    input logic e);
    @(posedge pclk);
    {s, h, c, k} <= {a, b, d, e};
  endtask
endmodule // sacse_src

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the status register bank.
// Assumes: Monitor limits are high 4 and low 2.
// Notes: Registers are reached by APB reads and writes.
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, v, pe, k;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] r0, r1, rt, hi, lo;
  logic [3:0] fl, s, h, c;
  int err_total = 0;
  int checks_done = 0;
  sacse_src u_src (.pclk(pclk), .v(v), .r0(r0), .r1(r1), .rt(rt), .hi(hi), .lo(lo), .pe(pe),
    .fl(fl), .s(s), .h(h), .c(c), .k(k));
  sacse_regs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mon_sample_valid(v), .monitor0_reading(r0), .monitor1_reading(r1),
    .temperature_reading(rt), .monitor0_high_limit(hi), .monitor0_low_limit(lo),
    .monitor1_high_limit(hi), .monitor1_low_limit(lo), .temperature_high_limit(hi),
    .temperature_low_limit(lo), .pkt_end(pe), .short_line_flag(fl[3]),
    .payload_check_fail(fl[2]), .header_double_error(fl[1]), .header_single_error(fl[0]),
    .lane_sync_soft_error(s), .lane_sync_hard_error(h), .lane_hs_request_ctrl_error(c),
    .clocklane_hs_request_ctrl_error(k), .irq(irq));
  // Free-running 250 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] x, input string n);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(n, q, x);
  endtask
  function automatic logic [31:0] lb(input logic [3:0] a, b, d, input int l);
    return {24'h0, a[l+1], b[l+1], d[l+1], 1'b0, a[l], b[l], d[l], 1'b0};
  endfunction
  task automatic t_mon();
    logic [31:0] q;
    logic e;
    u_src.sample(3'h5, 3'h1, 3'h7);
    u_src.sample(3'h6, 3'h0, 3'h3);
    u_src.sample(3'h5, 3'h3, 3'h1);
    rc(12'h160, 32'h67, "mon0");
    rc(12'h164, 32'h00, "mon1");
    rc(12'h168, 32'h71, "temp");
    rc(12'h15C, 32'h36, "alarms");
    rc(12'h160, 32'h07, "mon0_clr");
    rc(12'h15C, 32'h00, "alarms_clr");
    // Bits 7 and 3 are plain storage beside the cleared extremes.
    apb(1'b1, 12'h160, 32'h88, q, e);
    rc(12'h160, 32'h8F, "mon0_rsv");
  endtask
  task automatic t_pkt();
    for (int i = 0; i < 4; i++) u_src.pkt(4'h1 << i);
    u_src.pkt(4'h0);
    rc(12'h170, 32'h04, "count");
    rc(12'h174, 32'h0F, "flags");
    rc(12'h170, 32'h00, "count_clr");
    rc(12'h174, 32'h00, "flags_clr");
  endtask
  // An error landing on the clearing edge must survive it.
  task automatic t_same();
    fork
      rc(12'h170, 32'h00, "count_race");
      u_src.pkt(4'h8);
    join
    rc(12'h170, 32'h01, "count_kept");
    rc(12'h174, 32'h08, "flag_pre");
    fork
      rc(12'h174, 32'h00, "flag_race");
      u_src.pkt(4'h2);
    join
    rc(12'h174, 32'h02, "flag_kept");
  endtask
  task automatic t_lane();
    logic [3:0] ps[3] = '{4'hA, 4'h5, 4'h0};
    logic [3:0] ph[3] = '{4'h5, 4'hA, 4'h0};
    logic [3:0] pc[3] = '{4'h3, 4'hC, 4'h0};
    for (int j = 0; j < 3; j++) begin
      u_src.lanes(ps[j], ph[j], pc[j], ps[j][1]);
      repeat (2) @(posedge pclk);
      rc(12'h178, lb(ps[j], ph[j], pc[j], 0), "lane01");
      rc(12'h17C, lb(ps[j], ph[j], pc[j], 2), "lane23");
      rc(12'h180, {30'h0, ps[j][1], 1'b0}, "clklane");
    end
  endtask
  // Interrupt raised only once unmasked, dropped by the status read.
  task automatic t_irq();
    logic [31:0] q;
    logic e;
    rc(12'h1C0, 32'h07, "irq_sts");
    u_src.pkt(4'h1);
    repeat (3) @(posedge pclk);
    chk("irq_masked", irq, 1'b0);
    apb(1'b1, 12'h1C4, 32'h2, q, e);
    repeat (2) @(posedge pclk);
    chk("irq_on", irq, 1'b1);
    rc(12'h1C0, 32'h02, "irq_sts2");
    @(posedge pclk);
    chk("irq_off", irq, 1'b0);
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk("unmapped", {q[30:0], e}, 32'h1);
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cuts a hang short after ten thousand cycles.
  initial begin
    #40000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0000_0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(12'h168, 32'h07, "temp_rst");
    rc(12'h164, 32'h07, "mon1_rst");
    t_mon();
    t_pkt();
    t_same();
    t_lane();
    t_irq();
    tally_and_finish();
  end
endmodule // tb
